/* File: logic/mhb_pkg.sv */
package mhb_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 8;
   localparam logic [7:0]  ADDR_RST      = 8'h00;
   localparam logic [7:0]  DATA_RST      = 8'h00;
   // Bus style levels on the select pin
   localparam logic        STYLE_ENABLE  = 1'b0;
   localparam logic        STYLE_STROBE  = 1'b1;
   typedef enum logic [1:0] {MHB_IDLE, MHB_ADDR, MHB_READ} mhb_state_t;
endpackage

/* File: logic/mhb_edge.sv */
module mhb_edge (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic sig_in,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   import mhb_pkg::*;
   logic prev_r;
   logic prev_nxt;
   logic seen_r;
   logic seen_nxt;
   always_comb begin
      prev_nxt = sig_in;
      seen_nxt = 1'b1;
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prev_r <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
         seen_r <= seen_nxt;
      end
   end
   // No edge before one real sample, so a pin idling high never fakes one at reset
   assign level_o = sig_in;
   assign rise_o  = seen_r & sig_in & ~prev_r;
   assign fall_o  = seen_r & ~sig_in & prev_r;
endmodule

/* File: logic/mhb_port.sv */
// Functional notes
// - Low or open select means enable style
// - Address captured on address strobe fall
// - Write data on strobe fall or write-enable rise
// - Drive bus during read phase per style
// - Release bus when read phase ends
// - Deselected cycle latches address, no access
// - Power fail forces chip select inactive
// - Address strobe rise clears latched address
// - Strobe style: read/write high read, low write
// - Enable style: read/write is write enable
// - Reset low with power good refuses access
module mhb_port (
   input  wire logic                     clk_sys,
   input  wire logic                     resetn,
   input  wire logic                     bus_style_select,
   input  wire logic                     address_strobe,
   input  wire logic                     data_strobe,
   input  wire logic                     rd_wr,
   input  wire logic                     chip_sel_n,
   input  wire logic                     dev_reset_n,
   input  wire logic                     power_fail,
   input  wire logic [mhb_pkg::DATA_W-1:0] muxed_addr_data_bus_i,
   output logic [mhb_pkg::DATA_W-1:0]    muxed_addr_data_bus_o,
   output logic                          muxed_addr_data_bus_oe_n,
   output logic [mhb_pkg::ADDR_W-1:0]    mem_addr,
   output logic [mhb_pkg::DATA_W-1:0]    mem_wdata,
   output logic                          mem_we,
   output logic                          mem_re,
   input  wire logic [mhb_pkg::DATA_W-1:0] mem_rdata
);
   import mhb_pkg::*;

   // Edge views of the host strobes, flagged in the first cycle a pin shows its new level
   logic                as_rise;
   logic                as_fall;
   logic                ds_lvl;
   logic                ds_fall;
   logic                rw_lvl;
   logic                rw_rise;

   mhb_edge u_as (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .sig_in  (address_strobe),
      .level_o (),
      .rise_o  (as_rise),
      .fall_o  (as_fall)
   );

   mhb_edge u_ds (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .sig_in  (data_strobe),
      .level_o (ds_lvl),
      .rise_o  (),
      .fall_o  (ds_fall)
   );

   mhb_edge u_rw (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .sig_in  (rd_wr),
      .level_o (rw_lvl),
      .rise_o  (rw_rise),
      .fall_o  ()
   );

   logic                style_r, style_nxt;
   logic                style_ok_r, style_ok_nxt;
   logic [ADDR_W-1:0]   addr_r, addr_nxt;
   logic                addr_ok_r, addr_ok_nxt;
   logic [DATA_W-1:0]   dout_r, dout_nxt;
   logic                oe_n_r, oe_n_nxt;
   logic [DATA_W-1:0]   wdata_r, wdata_nxt;
   logic                we_r, we_nxt;
   logic                re_r, re_nxt;
   mhb_state_t          st_r, st_nxt;
   logic                sel;
   logic                rd_phase;
   logic                wr_take;
   logic                wr_live;
   logic                read_end;

   // Pin qualifiers folded into one internal select; power fail and reset win
   function automatic logic access_ok(input logic cs_n, input logic pf, input logic rst_n);
      return ~cs_n & ~pf & rst_n;
   endfunction

   function automatic logic read_window(input logic style, input logic ds, input logic rw);
      if (style == STYLE_STROBE) begin
         return ds & rw;
      end
      return ~ds & rw;
   endfunction

   function automatic logic write_edge(input logic style,
                                       input logic ds_f,
                                       input logic rw,
                                       input logic rw_r);
      if (style == STYLE_STROBE) begin
         return ds_f & ~rw;
      end
      return rw_r;
   endfunction

   // Style caught once after reset release; pin treated as strap
   always_comb begin
      style_nxt    = style_r;
      style_ok_nxt = 1'b1;
      if (!style_ok_r) begin
         style_nxt = bus_style_select;
      end
   end

   always_comb begin
      sel      = access_ok(chip_sel_n, power_fail, dev_reset_n);
      rd_phase = read_window(style_r, ds_lvl, rw_lvl);
      wr_take  = write_edge(style_r, ds_fall, rw_lvl, rw_rise);
      // A write edge coinciding with a new address belongs to no access
      wr_live  = wr_take && (st_r != MHB_IDLE) && !as_fall;
      read_end = !rd_phase || !sel || as_rise;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         style_r    <= STYLE_ENABLE;
         style_ok_r <= 1'b0;
      end else begin
         style_r    <= style_nxt;
         style_ok_r <= style_ok_nxt;
      end
   end

   // Sequencer: a read starts only from a live, selected address
   always_comb begin
      st_nxt = st_r;
      re_nxt = 1'b0;
      case (st_r)
         MHB_IDLE: begin
            if (as_fall) begin
               st_nxt = MHB_ADDR;
            end
         end
         MHB_ADDR: begin
            if (as_rise) begin
               st_nxt = MHB_IDLE;
            end else if (sel && addr_ok_r && rd_phase) begin
               st_nxt = MHB_READ;
               re_nxt = 1'b1;
            end
         end
         MHB_READ: begin
            if (read_end) begin
               st_nxt = MHB_ADDR;
            end
         end
         default: begin
            st_nxt = MHB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_r <= MHB_IDLE;
         re_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         re_r <= re_nxt;
      end
   end

   // Address latch; a refused access spends the address until a fresh strobe
   always_comb begin
      addr_nxt    = addr_r;
      addr_ok_nxt = addr_ok_r;
      if (as_fall) begin
         addr_nxt    = muxed_addr_data_bus_i;
         addr_ok_nxt = 1'b1;
      end else if (as_rise) begin
         addr_nxt    = ADDR_RST;
         addr_ok_nxt = 1'b0;
      end
      if (wr_live && !(sel && addr_ok_r)) begin
         addr_ok_nxt = 1'b0;
      end
      if (rd_phase && !sel && st_r == MHB_ADDR) begin
         addr_ok_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         addr_r    <= ADDR_RST;
         addr_ok_r <= 1'b0;
      end else begin
         addr_r    <= addr_nxt;
         addr_ok_r <= addr_ok_nxt;
      end
   end

   always_comb begin
      wdata_nxt = wdata_r;
      we_nxt    = 1'b0;
      if (wr_live && sel && addr_ok_r) begin
         wdata_nxt = muxed_addr_data_bus_i;
         we_nxt    = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wdata_r <= DATA_RST;
         we_r    <= 1'b0;
      end else begin
         wdata_r <= wdata_nxt;
         we_r    <= we_nxt;
      end
   end

   // Drive only from the read state; storage data follows each read-state cycle and holds otherwise
   always_comb begin
      dout_nxt = dout_r;
      oe_n_nxt = 1'b1;
      if (st_r == MHB_READ) begin
         dout_nxt = mem_rdata;
         if (!read_end) begin
            oe_n_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dout_r <= DATA_RST;
         oe_n_r <= 1'b1;
      end else begin
         dout_r <= dout_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   assign muxed_addr_data_bus_o    = dout_r;
   assign muxed_addr_data_bus_oe_n = oe_n_r;
   assign mem_addr                 = addr_r;
   assign mem_wdata                = wdata_r;
   assign mem_we                   = we_r;
   assign mem_re                   = re_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_as_rise_clear: assert property (as_rise |=> mem_addr == ADDR_RST)
      else $error("address not cleared on strobe rise");
   a_as_fall_cap: assert property (as_fall |=> mem_addr == $past(muxed_addr_data_bus_i))
      else $error("address not captured on strobe fall");
   a_pf_no_write: assert property (power_fail |=> !mem_we)
      else $error("write during power fail");
   a_rst_no_read: assert property (!dev_reset_n |=> !mem_re && muxed_addr_data_bus_oe_n)
      else $error("access while device reset low");
   a_desel_no_wr: assert property (chip_sel_n |=> !mem_we)
      else $error("write while deselected");
   a_drive_needs_rd: assert property (!muxed_addr_data_bus_oe_n |-> $past(rd_phase))
      else $error("bus driven outside read phase");
   a_release_end: assert property (st_r == MHB_READ && !rd_phase |=> muxed_addr_data_bus_oe_n)
      else $error("bus not released at read end");
   a_style_static: assert property (style_ok_r |=> $stable(style_r))
      else $error("style changed during operation");
   a_wr_strobe: assert property (mem_we && style_r == STYLE_STROBE |-> $past(ds_fall && !rw_lvl))
      else $error("strobe write without data strobe fall");
   a_wr_enable: assert property (mem_we && style_r == STYLE_ENABLE |-> $past(rw_rise))
      else $error("enable write without write enable rise");

   a_we_single: assert property (mem_we |=> !mem_we)
      else $error("write pulse longer than one cycle");
   a_re_single: assert property (mem_re |=> !mem_re)
      else $error("read pulse longer than one cycle");
   a_desel_no_rd: assert property (chip_sel_n |=> !mem_re)
      else $error("read while deselected");
   a_pf_no_drive: assert property (power_fail |=> muxed_addr_data_bus_oe_n)
      else $error("bus driven during power fail");
   a_rd_data: assert property (!muxed_addr_data_bus_oe_n |->
                               muxed_addr_data_bus_o == $past(mem_rdata))
      else $error("read data not from storage");

   c_write: cover property (mem_we);
   c_clear: cover property (as_rise ##1 mem_addr == ADDR_RST);
   c_refused: cover property (power_fail && rd_phase && st_r == MHB_ADDR);
   c_read: cover property (mem_re ##1 !muxed_addr_data_bus_oe_n);
   c_desel: cover property (as_fall ##[1:20] chip_sel_n && rd_phase);
endmodule

/* File: dv/mhb_host.sv */
module mhb_host (
   input  wire logic       clk_sys,
   input  wire logic       style,
   output logic            address_strobe,
   output logic            data_strobe,
   output logic            rd_wr,
   output logic            chip_sel_n,
   output logic [7:0]      bus_in,
   input  wire logic [7:0] bus_out,
   input  wire logic       bus_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] drv;
   logic       drv_en;
   // Released bus shows inverse, so stale data never reads back
   assign bus_in = !bus_oe_n ? bus_out : (drv_en ? drv : ~drv);
   task automatic go(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic idle();
      address_strobe = 1'b0;
      data_strobe = ~style;
      rd_wr = 1'b1;
      chip_sel_n = 1'b1;
      drv_en = 1'b0;
   endtask
   task automatic addr_phase(input logic [7:0] a, input logic cs);
      chip_sel_n = ~cs;
      drv = a;
      drv_en = 1'b1;
      address_strobe = 1'b1;
      go(2);
      address_strobe = 1'b0;
      go(2);
      drv_en = 1'b0;
   endtask
   task automatic data_phase(input logic wr, input logic [7:0] d, input logic cs,
                             output logic [7:0] rd);
      chip_sel_n = ~cs;
      rd_wr = ~wr;
      drv = d;
      drv_en = wr;
      go(1);
      if (style)
         data_strobe = 1'b1;
      else if (!wr)
         data_strobe = 1'b0;
      go(4);
      rd = bus_in;
      data_strobe = ~style;
      go(1);
      rd_wr = 1'b1;
      go(2);
      idle();
   endtask
endmodule

/* File: dv/mhb_port_test.sv */
module mhb_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys, resetn, style, address_strobe, data_strobe, rd_wr, chip_sel_n;
   logic       dev_reset_n, power_fail, oe_n, mem_we, mem_re;
   logic [7:0] bus_in, bus_out, mem_addr, mem_wdata, mem_rdata, wd, rd;
   int         err_total, n_checks, n_we, n_re;
   // Storage stand-in: data derived from the address
   assign mem_rdata = ~mem_addr;
   mhb_port u_dut (.clk_sys(clk_sys), .resetn(resetn), .bus_style_select(style),
      .address_strobe(address_strobe), .data_strobe(data_strobe), .rd_wr(rd_wr),
      .chip_sel_n(chip_sel_n), .dev_reset_n(dev_reset_n), .power_fail(power_fail),
      .muxed_addr_data_bus_i(bus_in), .muxed_addr_data_bus_o(bus_out),
      .muxed_addr_data_bus_oe_n(oe_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
   mhb_host u_host (.clk_sys(clk_sys), .style(style), .address_strobe(address_strobe),
      .data_strobe(data_strobe), .rd_wr(rd_wr), .chip_sel_n(chip_sel_n),
      .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(oe_n));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (mem_we === 1'b1) begin
         n_we++;
         wd = mem_wdata;
      end
      if (mem_re === 1'b1)
         n_re++;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset(input logic s);
      style = s;
      u_host.idle();
      resetn = 1'b0;
      repeat (16) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic t_access(input logic [7:0] a, input logic [7:0] d);
      int w0;
      int r0;
      w0 = n_we;
      r0 = n_re;
      u_host.addr_phase(a, 1'b1);
      chk(mem_addr, a);
      u_host.data_phase(1'b1, d, 1'b1, rd);
      chk(wd, d);
      chk(8'(n_we - w0), 8'h01);
      u_host.addr_phase(a, 1'b1);
      u_host.data_phase(1'b0, 8'h00, 1'b1, rd);
      chk(rd, ~a);
      chk(8'(n_re - r0), 8'h01);
      chk({7'h0, oe_n}, 8'h01);
   endtask
   task automatic t_clear(input logic [7:0] a);
      u_host.addr_phase(a, 1'b0);
      u_host.address_strobe = 1'b1;
      u_host.go(2);
      chk(mem_addr, 8'h00);
      u_host.address_strobe = 1'b0;
      u_host.go(2);
   endtask
   task automatic t_refused(input int m, input logic [7:0] a);
      int c0;
      c0 = n_we + n_re;
      power_fail = (m == 1);
      dev_reset_n = (m != 2);
      u_host.addr_phase(a, m != 0);
      if (m == 0)
         chk(mem_addr, a);
      u_host.data_phase(1'b1, 8'h77, m != 0, rd);
      // Selected write with no fresh strobe must also be ignored
      u_host.data_phase(1'b1, 8'h77, 1'b1, rd);
      u_host.data_phase(1'b0, 8'h00, m != 0, rd);
      chk(rd, 8'hff);
      chk(8'(n_we + n_re - c0), 8'h00);
      power_fail = 1'b0;
      dev_reset_n = 1'b1;
   endtask
   initial begin
      power_fail = 1'b0;
      dev_reset_n = 1'b1;
      for (int s = 0; s < 2; s++) begin
         do_reset(s[0]);
         t_access(8'h5a, 8'ha5);
         t_access(8'hff, 8'h00);
         t_clear(8'h3c);
         for (int m = 0; m < 3; m++)
            t_refused(m, 8'h81);
      end
      results();
   end
   initial begin
      #2ms;
      err_total++;
      results();
   end
endmodule
